//--- src/boot_flash_protection_and_self_program.v
// protection, addressing and self-program control of program flash
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "boot_prot_defs.vh"

// Behaviour
// - lock bits only program toward zero; only chip erase or reset restores ones
// - general write lock does not block store-to-program-memory
// - general read/write lock does not restrict loads or stores
// - application lock mode 1 allows all access to application section
// - application lock modes 2 and 3 refuse stores into application
// - application modes 3,4 refuse boot-executed loads of application
// - application modes 3,4 with boot vectors mask irqs in application
// - boot lock mode 1 allows all access to boot section
// - boot lock modes 2 and 3 refuse stores into boot section
// - boot modes 3,4 refuse application-executed loads of boot section
// - boot modes 3,4 with application vectors mask irqs in boot
// - reset vector is 0x0000 if boot fuse one, else boot address
// - no software path changes fuses
// - store address comes from 16-bit pointer: page and word fields
// - target address latched when an operation starts
// - lock-setting store ignores pointer contents
// - loads address bytes; pointer bit 0 selects low or high byte
// - page buffer loaded one word per store, before or after erase
// - page buffer accepts word loads in any order
// - erase or write to no-concurrent-read section stalls processor
module boot_flash_protection_and_self_program #(
  parameter PROG_CYCLES = `PROG_TIME_NS / `CLK_NS
) (
  input  wire        clk,                    // system clock 250 MHz
  input  wire        rstn,                   // sync reset, active low
  input  wire [3:0]  address,                // avalon word address
  input  wire        read,                   // avalon read
  input  wire        write,                  // avalon write
  input  wire [31:0] writedata,              // avalon write data
  input  wire [3:0]  byteenable,             // avalon byte enables
  output reg  [31:0] readdata,               // avalon read data
  output wire        waitrequest,            // avalon wait
  input  wire        boot_reset_select_fuse, // strap, 0 = programmed
  input  wire        execInBoot,             // core executes from boot
  input  wire        vectorsInBoot,          // vectors moved to boot
  input  wire        chipErase,              // external whole-chip erase
  output wire        irqMask,                // masks core interrupts
  output wire        cpuStall,               // halts core
  output reg  [15:0] resetVector,            // fetch address after reset
  output reg         flashWe,                // one-cycle word program
  output reg  [15:0] flashAddr,              // latched word address
  output reg  [15:0] flashWdata,             // word to program
  output reg         flashErase,             // one-cycle page erase
  input  wire [15:0] flashRdata              // flash word at flashAddr
);

  // ********************************
  // state encodings
  // ********************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_BUSY  = 4'b0010;
  localparam [3:0] ST_WRITE = 4'b0100;
  localparam [3:0] ST_READ  = 4'b1000;

  localparam [15:0] PROG_CNT = PROG_CYCLES[15:0];

  // ********************************
  // section decode
  // ********************************
  function inBoot;
    input [15:0] wordAddr;
    begin
      inBoot = (wordAddr >= `BOOT_START);
    end
  endfunction

  function inNrww;
    input [15:0] wordAddr;
    begin
      inNrww = (wordAddr >= `NO_CONCURRENT_READ_SECTION_START);
    end
  endfunction

  reg  [15:0] pointer_q;      // pointer high and low bytes
  reg  [7:0]  locks_q;        // lock byte, one means unprogrammed
  reg  [15:0] loadData_q;     // word staged for a page load
  reg  [7:0]  loadByte_q;     // byte returned by the last load
  reg  [2:0]  cmd_q;          // last command code
  reg         refused_q;      // last operation refused
  reg  [3:0]  state_q;        // sequencer state
  reg  [15:0] count_q;        // programming time counter
  reg  [15:0] opAddr_q;       // latched target word address
  reg         opWrite_q;      // latched: write (1) or erase (0)
  reg  [`WORD_BITS-1:0] wIdx_q; // word index during page write
  reg         fuseSeen_q;     // strap captured after reset
  reg         bootFuse_q;     // captured boot-reset fuse
  reg         fuseSync1_q;    // strap synchroniser stage 1
  reg         fuseSync2_q;    // strap synchroniser stage 2
  reg         nrwwOp_q;       // operation targets stall section
  reg         ack_q;          // bus answer pulse

  wire [1:0]  appMode  = locks_q[3:2];
  wire [1:0]  bootMode = locks_q[5:4];
  wire        busReq   = read | write;
  wire [15:0] zWord    = {1'b0, pointer_q[15:1]};

  // general lock bits 1:0 never enter these terms
  wire appStoreBlk  = (appMode == `LOCK_MODE2) || (appMode == `LOCK_MODE3);
  wire bootStoreBlk = (bootMode == `LOCK_MODE2) ||
                      (bootMode == `LOCK_MODE3);
  wire appReadBlk   = (appMode == `LOCK_MODE3) || (appMode == `LOCK_MODE4);
  wire bootReadBlk  = (bootMode == `LOCK_MODE3) ||
                      (bootMode == `LOCK_MODE4);

  // mode 1 sets no block term, so access passes
  wire storeBlk = inBoot(zWord) ? bootStoreBlk : appStoreBlk;
  wire loadBlk  = inBoot(zWord) ? (!execInBoot && bootReadBlk)
                                : (execInBoot && appReadBlk);

  // ********************************
  // interrupt masking
  // ********************************
  // masked in application when vectors sit in boot
  // masked in boot when vectors sit in application
  assign irqMask = (vectorsInBoot && !execInBoot && appReadBlk) ||
                   (!vectorsInBoot && execInBoot && bootReadBlk);

  // stall for the whole of an operation on the stall section
  assign cpuStall = (state_q != ST_IDLE) && nrwwOp_q;

  // bus waits while load sequencing runs; ack ends every access
  assign waitrequest = busReq && !ack_q;

  wire wrHit = write && !ack_q;
  wire cmdGo = wrHit && (address == `OFS_COMMAND) &&
               (state_q == ST_IDLE);

  // ********************************
  // reset vector from strap
  // ********************************
  // fuse is an input only; no bus write reaches it
  always @(posedge clk) begin
    fuseSync1_q <= boot_reset_select_fuse;
    fuseSync2_q <= fuseSync1_q;
    if (!rstn) begin
      fuseSeen_q  <= 1'b0;
      bootFuse_q  <= 1'b1;
      resetVector <= `APP_VECTOR;
    end else begin
      if (!fuseSeen_q) begin
        fuseSeen_q <= 1'b1;
        bootFuse_q <= fuseSync2_q;
      end
      // one selects zero, zero selects boot
      resetVector <= (fuseSeen_q ? bootFuse_q : fuseSync2_q) ?
                     `APP_VECTOR : `BOOT_VECTOR;
    end
  end

  // ********************************
  // page buffer
  // ********************************
  wire        bufLoad = cmdGo && (writedata[2:0] == `CMD_PAGE_LOAD);
  wire        bufClr  = (state_q == ST_WRITE) && (count_q == 16'h0000) &&
                        (wIdx_q == {`WORD_BITS{1'b1}});
  wire [15:0] bufRd;
  // read one word ahead: the buffer output is registered, so each
  // program pulse must see the word of its own index, not the last one
  wire [`WORD_BITS-1:0] rdNext =
    ((state_q == ST_WRITE) && (count_q == 16'h0000)) ?
    wIdx_q + {{(`WORD_BITS-1){1'b0}}, 1'b1} : wIdx_q;

  // one word per load, legal before or after the erase
  page_buffer u_buf (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (bufLoad),
    .wrIdx  (zWord[`WORD_BITS-1:0]),
    .wrData (loadData_q),
    .clrAll (bufClr),
    .rdIdx  (rdNext),
    .rdData (bufRd)
  );

  // ********************************
  // register file, commands and sequencer
  // ********************************
  always @(posedge clk) begin
    if (!rstn) begin
      pointer_q  <= 16'h0000;
      locks_q    <= `LOCKS_ERASED;
      loadData_q <= 16'h0000;
      loadByte_q <= 8'h00;
      cmd_q      <= 3'h0;
      refused_q  <= 1'b0;
      state_q    <= ST_IDLE;
      count_q    <= 16'h0000;
      opAddr_q   <= 16'h0000;
      opWrite_q  <= 1'b0;
      wIdx_q     <= {`WORD_BITS{1'b0}};
      nrwwOp_q   <= 1'b0;
      ack_q      <= 1'b0;
      readdata   <= `UNMAPPED_DATA;
      flashWe    <= 1'b0;
      flashErase <= 1'b0;
      flashAddr  <= 16'h0000;
      flashWdata <= 16'h0000;
    end else begin
      flashWe    <= 1'b0;
      flashErase <= 1'b0;
      ack_q      <= 1'b0;
      // loads take a flash read cycle; others answer next edge
      if (busReq && !ack_q && !(cmdGo &&
          writedata[2:0] == `CMD_LOAD_BYTE)) begin
        ack_q <= (state_q != ST_READ);
      end
      if (read && !ack_q) begin
        case (address)
          `OFS_POINTER:  readdata <= {16'h0000, pointer_q};
          `OFS_LOCKS:    readdata <= {24'h000000, locks_q};
          `OFS_FUSE:     readdata <= {31'h0, bootFuse_q};
          `OFS_COMMAND:  readdata <= {29'h0, cmd_q};
          `OFS_STATUS:   readdata <= {27'h0, refused_q, state_q};
          `OFS_BUFDATA:  readdata <= {24'h000000, loadByte_q};
          `OFS_LOADDATA: readdata <= {16'h0000, loadData_q};
          default:       readdata <= `UNMAPPED_DATA;
        endcase
      end
      if (wrHit && address == `OFS_POINTER) begin
        if (byteenable[0]) pointer_q[7:0]  <= writedata[7:0];
        if (byteenable[1]) pointer_q[15:8] <= writedata[15:8];
      end
      if (wrHit && address == `OFS_LOADDATA) begin
        if (byteenable[0]) loadData_q[7:0]  <= writedata[7:0];
        if (byteenable[1]) loadData_q[15:8] <= writedata[15:8];
      end
      // besides reset, chip erase alone returns lock bits to one
      if (chipErase) begin
        locks_q <= `LOCKS_ERASED;
      end else if (wrHit && address == `OFS_LOCKS) begin
        locks_q <= locks_q & writedata[7:0];
      end
      case (state_q)
        ST_IDLE: begin
          if (cmdGo) begin
            cmd_q     <= writedata[2:0];
            refused_q <= 1'b0;
            case (writedata[2:0])
              `CMD_PAGE_ERASE, `CMD_PAGE_WRITE: begin
                if (storeBlk) begin
                  refused_q <= 1'b1;
                end else begin
                  opAddr_q  <= {zWord[15:`WORD_BITS],
                                {`WORD_BITS{1'b0}}};
                  opWrite_q <= (writedata[2:0] == `CMD_PAGE_WRITE);
                  nrwwOp_q  <= inNrww(zWord);
                  count_q   <= PROG_CNT;
                  wIdx_q    <= {`WORD_BITS{1'b0}};
                  state_q   <= (writedata[2:0] == `CMD_PAGE_WRITE) ?
                               ST_WRITE : ST_BUSY;
                end
              end
              `CMD_LOCK_SET: begin
                // bits only program toward zero; chip erase wins
                if (!chipErase) begin
                  locks_q <= locks_q & loadData_q[7:0];
                end
              end
              `CMD_LOAD_BYTE: begin
                if (loadBlk) begin
                  refused_q  <= 1'b1;
                  loadByte_q <= 8'h00;
                  ack_q      <= 1'b1;
                end else begin
                  flashAddr <= zWord;
                  state_q   <= ST_READ;
                end
              end
              default: ;
            endcase
          end
        end
        ST_READ: begin
          // pointer bit 0 picks the byte
          loadByte_q <= pointer_q[0] ? flashRdata[15:8] : flashRdata[7:0];
          ack_q      <= 1'b1;
          state_q    <= ST_IDLE;
        end
        ST_BUSY: begin
          flashAddr <= opAddr_q;
          if (count_q == PROG_CNT) flashErase <= 1'b1;
          if (count_q == 16'h0000) state_q <= ST_IDLE;
          else count_q <= count_q - 16'h0001;
        end
        ST_WRITE: begin
          // wait the programming time, then burst the buffer to flash word by word
          flashAddr  <= opAddr_q | {{(16-`WORD_BITS){1'b0}}, wIdx_q};
          flashWdata <= bufRd;
          if (count_q == 16'h0000) begin
            flashWe <= 1'b1;
            if (wIdx_q == {`WORD_BITS{1'b1}}) state_q <= ST_IDLE;
            wIdx_q <= wIdx_q + {{(`WORD_BITS-1){1'b0}}, 1'b1};
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- src/boot_prot_defs.vh
// constants for the boot flash protection and self-program block
`ifndef BOOT_PROT_DEFS_VH
`define BOOT_PROT_DEFS_VH

// ********************************
// register word offsets (word address)
// ********************************
`define OFS_POINTER     4'h0
`define OFS_LOCKS       4'h1
`define OFS_FUSE        4'h2
`define OFS_COMMAND     4'h3
`define OFS_STATUS      4'h4
`define OFS_BUFDATA     4'h5
`define OFS_LOADADDR    4'h6
`define OFS_LOADDATA    4'h7
`define OFS_EXEC        4'h8

// ********************************
// command codes written to the command register
// ********************************
`define CMD_PAGE_LOAD   3'h1
`define CMD_PAGE_ERASE  3'h2
`define CMD_PAGE_WRITE  3'h3
`define CMD_LOCK_SET    3'h4
`define CMD_LOAD_BYTE   3'h5
`define CMD_CHIP_ERASE  3'h6

// ********************************
// geometry and reset values
// ********************************
`define WORD_BITS       6
`define PAGE_WORDS      64
`define BOOT_START      16'h3800
`define NO_CONCURRENT_READ_SECTION_START      16'h3800
`define BOOT_VECTOR     16'h3800
`define APP_VECTOR      16'h0000
`define LOCKS_ERASED    8'hff
`define LOCK_MODE1      2'h3
`define LOCK_MODE2      2'h2
`define LOCK_MODE3      2'h0
`define LOCK_MODE4      2'h1
`define PROG_TIME_NS    4000
`define CLK_NS          4
`define UNMAPPED_DATA   32'h00000000

`endif

//--- src/page_buffer.v
// temporary page buffer, one word per load, any word offset
`timescale 1ns/1ps
`include "boot_prot_defs.vh"

module page_buffer (
  input  wire                  clk,      // system clock
  input  wire                  rstn,     // sync reset, active low
  input  wire                  wrEn,     // load one word
  input  wire [`WORD_BITS-1:0] wrIdx,    // word offset in page
  input  wire [15:0]           wrData,   // word to load
  input  wire                  clrAll,   // auto-erase after page write
  input  wire [`WORD_BITS-1:0] rdIdx,    // word offset to read
  output reg  [15:0]           rdData    // registered read word
);

  reg [15:0] mem [0:`PAGE_WORDS-1];
  integer i;

  // ********************************
  // storage; erased to all ones like blank flash
  // ********************************
  // random-order word loads
  always @(posedge clk) begin
    if (!rstn || clrAll) begin
      for (i = 0; i < `PAGE_WORDS; i = i + 1) begin
        mem[i] <= 16'hffff;
      end
    end else if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end

endmodule

//--- testbench/boot_prot_props.sv
// checker for the boot flash protection block, bound to its ports
`timescale 1ns/1ps
`include "boot_prot_defs.vh"

module boot_prot_props #(
  parameter PROG_CYCLES = 4
) (
  input wire logic        clk,                    // system clock
  input wire logic        rstn,                   // sync reset
  input wire logic [3:0]  address,                // bus address
  input wire logic        read,                   // bus read
  input wire logic        write,                  // bus write
  input wire logic [31:0] writedata,              // bus write data
  input wire logic [31:0] readdata,               // bus read data
  input wire logic        waitrequest,            // bus wait
  input wire logic        boot_reset_select_fuse, // boot fuse strap
  input wire logic        execInBoot,             // fetching from boot
  input wire logic        vectorsInBoot,          // vectors in boot
  input wire logic        chipErase,              // whole-chip erase
  input wire logic        irqMask,                // irq mask out
  input wire logic        cpuStall,               // core halt
  input wire logic [15:0] resetVector,            // reset fetch address
  input wire logic        flashWe,                // word program
  input wire logic        flashErase,             // page erase
  input wire logic [15:0] flashAddr               // flash word address
);
  // ****************
  // shadow of locks and pointer
  // ****************
  logic [7:0]  lockQ;
  logic [15:0] ptrQ, cmdPtr;
  logic [7:0]  ldQ;
  logic [2:0]  rstCnt;
  // a write is taken on the edge where it is still waiting
  wire         wAck = write && waitrequest;

  // lock bits only move toward zero; chip erase restores ones
  always @(posedge clk) begin
    if (!rstn) begin
      lockQ  <= 8'hff;
      rstCnt <= 3'h0;
    end else begin
      if (rstCnt != 3'h5) rstCnt <= rstCnt + 3'h1;
      if (chipErase) lockQ <= 8'hff;
      else if (wAck && address == `OFS_LOCKS)
        lockQ <= lockQ & writedata[7:0];
      else if (wAck && address == `OFS_COMMAND &&
               writedata[2:0] == `CMD_LOCK_SET)
        lockQ <= lockQ & ldQ;
      if (wAck && address == `OFS_LOADDATA) ldQ <= writedata[7:0];
      if (wAck && address == `OFS_POINTER) ptrQ <= writedata[15:0];
      // pointer seen when a command is taken, later edits ignored
      if (wAck && address == `OFS_COMMAND) cmdPtr <= ptrQ;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_irq_app_exec: assert property (!execInBoot |->
    irqMask == (vectorsInBoot && !lockQ[3])) else $error("irq mask app");
  a_irq_boot_exec: assert property (execInBoot |->
    irqMask == (!vectorsInBoot && !lockQ[5])) else $error("irq mask boot");
  a_reset_vec_sel: assert property (rstCnt == 3'h4 &&
    $stable(boot_reset_select_fuse) &&
    boot_reset_select_fuse == $past(boot_reset_select_fuse, 2) &&
    boot_reset_select_fuse == $past(boot_reset_select_fuse, 3) |->
    resetVector == (boot_reset_select_fuse ? `APP_VECTOR : `BOOT_VECTOR))
    else $error("reset vector wrong");
  a_app_store_lock: assert property ((flashErase || flashWe) &&
    flashAddr < `BOOT_START |-> lockQ[2]) else $error("app store leaked");
  a_boot_store_lock: assert property ((flashErase || flashWe) &&
    flashAddr >= `BOOT_START |-> lockQ[4]) else $error("boot store leaked");
  a_stall_no_concurrent_read_section: assert property (flashErase &&
    flashAddr >= `NO_CONCURRENT_READ_SECTION_START |-> cpuStall) else $error("no stall");
  a_erase_page_latched: assert property (flashErase |->
    flashAddr[15:6] == {1'b0, cmdPtr[15:7]}) else $error("erase page");
  a_lock_readback: assert property (read && !waitrequest &&
    address == `OFS_LOCKS |-> readdata[5:0] == lockQ[5:0])
    else $error("lock readback");
endmodule

bind boot_flash_protection_and_self_program boot_prot_props #(
  .PROG_CYCLES(PROG_CYCLES)
) i_props (.clk, .rstn, .address, .read, .write, .writedata, .readdata,
  .waitrequest, .boot_reset_select_fuse, .execInBoot, .vectorsInBoot,
  .chipErase, .irqMask, .cpuStall, .resetVector, .flashWe, .flashErase,
  .flashAddr);

//--- testbench/flash_model.sv
// behavioural program flash array behind the block
`timescale 1ns/1ps

module flash_model (
  input  wire logic        clk,   // system clock
  input  wire logic        we,    // program one word
  input  wire logic        erase, // erase page of addr
  input  wire logic [15:0] addr,  // word address
  input  wire logic [15:0] wdata, // word to program
  output logic      [15:0] rdata  // word at addr
);
  logic [15:0] mem [int];
  logic        tick = 1'b0;

  // erased cells read as ones; untouched cells hold a per-address pattern
  always @(posedge clk) begin
    if (erase)
      for (int i = 0; i < 64; i++) mem[{addr[15:6], 6'h0} + i] = 16'hffff;
    if (we) mem[addr] = wdata;
    tick <= ~tick;
  end
  always @(addr or tick) rdata = mem.exists(addr) ? mem[addr] : ~addr;
endmodule

//--- testbench/tb_boot_flash_protection_and_self_program.sv
// self-checking bench for the boot flash protection block
`timescale 1ns/1ps
`include "boot_prot_defs.vh"

module tb_boot_flash_protection_and_self_program;
  localparam int PC = 4;
  logic        clk = 1'b0;
  logic        rstn, read, write, boot_reset_select_fuse, f;
  logic        execInBoot, vectorsInBoot, chipErase, irqMask, cpuStall;
  logic        waitrequest, flashWe, flashErase;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, q, r;
  logic [15:0] resetVector, flashAddr, flashWdata, flashRdata, p;
  logic [15:0] wd [4];
  logic [1:0]  m;
  logic [7:0]  lk;
  logic [5:0]  offs [4] = '{6'h3f, 6'h11, 6'h00, 6'h05};
  logic [1:0]  modes [4] = '{`LOCK_MODE1, `LOCK_MODE2, `LOCK_MODE3,
                             `LOCK_MODE4};
  int          n_mismatch = 0, comparisons = 0, cyc = 0;

  boot_flash_protection_and_self_program #(.PROG_CYCLES(PC)) i_dut (
    .clk, .rstn, .address, .read, .write, .writedata, .byteenable(4'hf),
    .readdata, .waitrequest, .boot_reset_select_fuse, .execInBoot,
    .vectorsInBoot, .chipErase, .irqMask, .cpuStall, .resetVector,
    .flashWe, .flashAddr, .flashWdata, .flashErase, .flashRdata);
  flash_model i_flash (.clk, .we(flashWe), .erase(flashErase),
    .addr(flashAddr), .wdata(flashWdata), .rdata(flashRdata));

  initial forever #2 clk = ~clk;

  // watchdog cuts a hung handshake short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // hold the request until waitrequest is seen low, idle one cycle after
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [15:0] ptr);
    bus(1'b1, `OFS_POINTER, {16'h0, ptr});
    bus(1'b1, `OFS_COMMAND, {29'h0, c});
  endtask

  task automatic ld_byte(input logic [15:0] ptr);
    cmd(`CMD_LOAD_BYTE, ptr);
    bus(1'b0, `OFS_BUFDATA, 32'h0);
  endtask

  task automatic pulse_erase;
    chipErase <= 1'b1;
    @(posedge clk);
    chipErase <= 1'b0;
    @(posedge clk);
  endtask

  // byte of a never-programmed flash word, as the flash model shows it
  function automatic logic [7:0] pat_byte(input logic [15:0] ptr);
    logic [15:0] w;
    w = ~{1'b0, ptr[15:1]};
    return ptr[0] ? w[15:8] : w[7:0];
  endfunction

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    boot_reset_select_fuse = 1'b0;
    execInBoot = 1'b0;
    vectorsInBoot = 1'b0;
    chipErase = 1'b0;
    r = $urandom(32'h3b30);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    check("resetVector", resetVector, `BOOT_VECTOR);
    boot_reset_select_fuse <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    check("resetVector", resetVector, `APP_VECTOR);
    bus(1'b0, 4'hf, 32'h0);
    check("unmapped", q, `UNMAPPED_DATA);
    // every lock mode of each field, general lock bits random
    for (int i = 0; i < 8; i++) begin
      f = i[2];
      m = modes[i[1:0]];
      r = $urandom;
      pulse_erase();
      lk = f ? {2'b11, m, 4'hf} : {4'hf, m, 2'b11};
      lk[1:0] = r[9:8];
      bus(1'b1, `OFS_LOCKS, {24'h0, lk});
      bus(1'b1, `OFS_LOCKS, 32'hff);
      bus(1'b0, `OFS_LOCKS, 32'h0);
      check("locks", q[5:0], lk[5:0]);
      vectorsInBoot <= r[10];
      execInBoot <= f;
      p = {f ? 4'h7 : 4'h2, 1'b0, i[2:0], r[7:0]};
      cmd(`CMD_PAGE_ERASE, p);
      repeat (PC + 4) @(posedge clk);
      ld_byte(p);
      check("eraseResult", q[7:0], m[0] ? 8'hff : pat_byte(p));
      execInBoot <= !f;
      ld_byte(p);
      check("crossLoad", q[7:0],
            m[1] ? (m[0] ? 8'hff : pat_byte(p)) : 8'h00);
    end
    // lock set by command ANDs the staged byte, pointer ignored
    pulse_erase();
    bus(1'b1, `OFS_LOADDATA, 32'hcf);
    cmd(`CMD_LOCK_SET, 16'h1234);
    bus(1'b0, `OFS_LOCKS, 32'h0);
    check("lockSet", q[5:0], 6'h0f);
    // erase, fill out of order, write the same page
    pulse_erase();
    execInBoot <= 1'b1;
    p = 16'h2000;
    cmd(`CMD_PAGE_ERASE, p);
    repeat (PC + 4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      wd[k] = 16'($urandom);
      bus(1'b1, `OFS_LOADDATA, {16'h0, wd[k]});
      cmd(`CMD_PAGE_LOAD, p | {9'h0, offs[k], 1'b0});
    end
    cmd(`CMD_PAGE_WRITE, p);
    bus(1'b1, `OFS_POINTER, 32'h7f00);
    repeat (PC + 80) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      ld_byte(p | {9'h0, offs[k], 1'b0});
      check("pageLow", q[7:0], wd[k][7:0]);
      ld_byte(p | {9'h0, offs[k], 1'b1});
      check("pageHigh", q[7:0], wd[k][15:8]);
    end
    close_out();
  end
endmodule
